/* common/vie_consts.vh */
// Constants for the vectored interrupt encoder
`ifndef VIE_CONSTS_VH
`define VIE_CONSTS_VH

// Register map
`define VIE_VEC_OFFSET 12'h000
`define VIE_VEC_RESET 8'h00
`define VIE_NONE_VEC 8'h00

// Vector field layout
`define VIE_GRP_MSB 7
`define VIE_GRP_LSB 4
`define VIE_IDX_MSB 3
`define VIE_IDX_LSB 1
`define VIE_ZERO_BIT 0

// Populated groups run from first to last; higher groups are empty
`define VIE_GRP_FIRST 4'h1
`define VIE_GRP_LAST 8
`define VIE_GRP_SRCS 8

`endif

/* design/vie_fcfs_group.v */
// One source group: sticky pending flags with first-come-first-served choice
`timescale 1ns/1ps
module vie_fcfs_group #(
  parameter N = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Source events and retire request
  input wire [N-1:0] set_in,
  input wire clr,
  input wire [2:0] clr_idx,
  // Pending state and choice for the next cycle
  output reg [N-1:0] pend_q,
  output reg sel_valid,
  output reg [2:0] sel_idx
);

  // older_q[i*N+j] is set when source i arrived before source j
  reg [N*N-1:0] older_q;
  reg [N*N-1:0] older_d;
  reg [N-1:0] pend_d;
  reg [N-1:0] kept;
  reg [N-1:0] newly;
  reg [N-1:0] clrmask;
  reg blocked;
  reg found;
  integer i;
  integer j;

  always @*
  begin
    clrmask = {N{1'b0}};
    if (clr)
    begin
      clrmask[clr_idx] = 1'b1;
    end
    kept = pend_q & ~clrmask;
    // A new event in the retire cycle survives the clear
    pend_d = kept | set_in;
    newly = set_in & ~kept;
    for (i = 0; i < N; i = i + 1)
    begin
      for (j = 0; j < N; j = j + 1)
      begin
        if (newly[i])
        begin
          // Simultaneous arrivals: the lower index counts as first
          older_d[i*N+j] = newly[j] && (i < j);
        end
        else
        begin
          older_d[i*N+j] = newly[j] ? 1'b1 : older_q[i*N+j];
        end
      end
    end
    sel_valid = 1'b0;
    sel_idx = 3'h0;
    found = 1'b0;
    for (i = 0; i < N; i = i + 1)
    begin
      blocked = 1'b0;
      for (j = 0; j < N; j = j + 1)
      begin
        if (pend_d[j] && older_d[j*N+i])
        begin
          blocked = 1'b1;
        end
      end
      if (pend_d[i] && !blocked && !found)
      begin
        found = 1'b1;
        sel_valid = 1'b1;
        sel_idx = i[2:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= {N{1'b0}};
      older_q <= {(N*N){1'b0}};
    end
    else
    begin
      pend_q <= pend_d;
      older_q <= older_d;
    end
  end

endmodule

/* design/vie_top.v */
// Vectored interrupt encoder with an APB slave for the vector register
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "vie_consts.vh"
module vie_top #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // USB endpoint events, bit n is endpoint n
  input wire [7:0] out_ep_event,
  input wire [7:0] in_ep_event,
  // USB control events
  input wire setup_overwrite,
  input wire setup_received,
  input wire usb_resume_event,
  input wire usb_suspend_event,
  input wire usb_bus_reset_event,
  input wire usb_wakeup_event,
  // I2C port events
  input wire i2c_transmit_empty,
  input wire i2c_receive_full,
  // Serial port events, bit 0 first port, bit 1 second port
  input wire [1:0] uart_line_status,
  input wire [1:0] uart_modem_status,
  input wire [1:0] uart_receive_full,
  input wire [1:0] uart_transmit_empty,
  // Parallel port events
  input wire parallel_port_receive_full,
  input wire parallel_port_transmit_empty,
  input wire printer_fault,
  input wire parallel_port_ack,
  input wire paper_error,
  // DMA channel events, bit 0 is the first channel
  input wire [4:0] dma_done,
  // Vector and request to the processor
  output reg [7:0] interrupt_vector,
  output reg ext_int0_request,
  output reg external_irq_out_n,
  // Endpoint pending flags
  output wire [7:0] input_endpoint_pending,
  output wire [7:0] output_endpoint_pending
);

  localparam NG = `VIE_GRP_LAST - `VIE_GRP_FIRST + 1;
  localparam NS = `VIE_GRP_SRCS;

  // Builds a vector from a group number and a source index
  function [7:0] make_vec;
    input [3:0] grp;
    input [2:0] idx;
    begin
      make_vec = 8'h00;
      make_vec[`VIE_GRP_MSB:`VIE_GRP_LSB] = grp;
      make_vec[`VIE_IDX_MSB:`VIE_IDX_LSB] = idx;
      make_vec[`VIE_ZERO_BIT] = 1'b0;
    end
  endfunction

  // Source events per group, group 1 in the lowest byte
  wire [NG*NS-1:0] grp_set;
  wire [NG*NS-1:0] grp_pend;
  wire [NG-1:0] grp_valid;
  wire [NG*3-1:0] grp_idx;
  wire [NG-1:0] grp_clr;

  // Index 0 of the endpoint groups is never set
  assign grp_set[0*NS +: NS] = {out_ep_event[7:1], 1'b0};
  assign grp_set[1*NS +: NS] = {in_ep_event[7:1], 1'b0};
  // Indices 2 and 3 of the control group are reserved
  assign grp_set[2*NS +: NS] = {usb_wakeup_event, usb_bus_reset_event,
                                usb_suspend_event, usb_resume_event, 2'b00,
                                setup_received, setup_overwrite};
  assign grp_set[3*NS +: NS] = {4'h0, out_ep_event[0], in_ep_event[0],
                                i2c_receive_full, i2c_transmit_empty};
  assign grp_set[4*NS +: NS] = {4'h0, uart_modem_status[1], uart_line_status[1],
                                uart_modem_status[0], uart_line_status[0]};
  assign grp_set[5*NS +: NS] = {4'h0, uart_transmit_empty[1], uart_receive_full[1],
                                uart_transmit_empty[0], uart_receive_full[0]};
  assign grp_set[6*NS +: NS] = {3'h0, paper_error, parallel_port_ack, printer_fault,
                                parallel_port_transmit_empty,
                                parallel_port_receive_full};
  assign grp_set[7*NS +: NS] = {3'h0, dma_done};

  // Endpoint flags straight from the group flip-flops
  assign output_endpoint_pending = {grp_pend[0*NS+1 +: 7], grp_pend[3*NS+3]};
  assign input_endpoint_pending = {grp_pend[1*NS+1 +: 7], grp_pend[3*NS+2]};

  // APB decode
  wire addr_hit;
  wire access;
  wire retire;
  assign addr_hit = (paddr == `VIE_VEC_OFFSET);
  assign access = psel & penable & pready;
  // Any data value retires; the shown vector names the flag to clear
  assign retire = access & pwrite & addr_hit & (interrupt_vector != `VIE_NONE_VEC);

  genvar g;
  generate
    for (g = 0; g < NG; g = g + 1)
    begin : grp
      assign grp_clr[g] = retire &&
        (interrupt_vector[`VIE_GRP_MSB:`VIE_GRP_LSB] == g + `VIE_GRP_FIRST);
      vie_fcfs_group #(
        .N(NS)
      ) u_grp (
        .pclk(pclk),
        .presetn(presetn),
        .set_in(grp_set[g*NS +: NS]),
        .clr(grp_clr[g]),
        .clr_idx(interrupt_vector[`VIE_IDX_MSB:`VIE_IDX_LSB]),
        .pend_q(grp_pend[g*NS +: NS]),
        .sel_valid(grp_valid[g]),
        .sel_idx(grp_idx[g*3 +: 3])
      );
    end
  endgenerate

  // Fixed priority between groups, highest group number first
  reg [7:0] best_vec;
  reg best_found;
  integer k;
  always @*
  begin
    best_vec = `VIE_NONE_VEC;
    best_found = 1'b0;
    for (k = NG - 1; k >= 0; k = k - 1)
    begin
      if (grp_valid[k] && !best_found)
      begin
        best_found = 1'b1;
        best_vec = make_vec(k[3:0] + `VIE_GRP_FIRST, grp_idx[k*3 +: 3]);
      end
    end
  end

  // The shown vector is held until retired, so a later higher source cannot
  // swap it between the read and the retiring write; it is taken next.
  reg [7:0] vec_d;
  always @*
  begin
    if (retire || interrupt_vector == `VIE_NONE_VEC)
    begin
      vec_d = best_vec;
    end
    else
    begin
      vec_d = interrupt_vector;
    end
  end

  // Vector and level request
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interrupt_vector <= `VIE_VEC_RESET;
      ext_int0_request <= 1'b0;
      external_irq_out_n <= 1'b1;
    end
    else
    begin
      interrupt_vector <= vec_d;
      // Level request: stays while anything is pending
      ext_int0_request <= (vec_d != `VIE_NONE_VEC);
      external_irq_out_n <= (vec_d == `VIE_NONE_VEC);
    end
  end

  // APB answer: one wait state so that all outputs are registered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready)
      begin
        pslverr <= ~addr_hit;
        if (!pwrite && addr_hit)
        begin
          prdata <= {24'h00_0000, interrupt_vector};
        end
        else
        begin
          prdata <= 32'h0000_0000;
        end
      end
      else
      begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

/* tb/vie_top_asserts.sv */
// Checker for the vector register, the request level and the APB answer
`timescale 1ns/1ps
module vie_top_asserts #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Source and outputs
  input wire [4:0] dma_done,
  input wire [7:0] interrupt_vector,
  input wire ext_int0_request,
  input wire external_irq_out_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire done = psel && penable && pready;
  wire [3:0] grp = interrupt_vector[7:4];
  wire [2:0] idx = interrupt_vector[3:1];
  chk_bit0_zero: assert property (interrupt_vector[0] == 1'b0)
    else $error("vector bit 0 set");
  chk_req_level: assert property (ext_int0_request == (interrupt_vector != 8'h00))
    else $error("request does not follow vector");
  chk_irq_inverse: assert property (external_irq_out_n != ext_int0_request)
    else $error("low request not inverse");
  chk_group_range: assert property (interrupt_vector != 8'h00 |-> grp >= 1 && grp <= 8)
    else $error("empty group shown");
  chk_unused_index: assert property (grp == 4'h7 || grp == 4'h8 |-> idx <= 3'h4)
    else $error("unused index shown");
  chk_mid_index: assert property (grp >= 4'h4 && grp <= 4'h6 |-> idx <= 3'h3)
    else $error("unused mid group index shown");
  chk_reserved_index: assert property (grp == 4'h3 |-> idx != 3'h2 && idx != 3'h3)
    else $error("reserved vector shown");
  chk_endpoint_zero: assert property (grp == 4'h1 || grp == 4'h2 |-> idx != 3'h0)
    else $error("unused endpoint index shown");
  chk_vector_hold: assert property (interrupt_vector != 8'h00 &&
    !(done && pwrite && paddr == '0) |=> $stable(interrupt_vector))
    else $error("vector changed without retire");
  chk_top_priority: assert property (interrupt_vector == 8'h00 && dma_done == 5'h10
    |=> interrupt_vector == 8'h88)
    else $error("highest source not shown");
  chk_read_value: assert property (done && !pwrite && paddr == '0
    |-> prdata == {24'h0, $past(interrupt_vector)})
    else $error("read data differs from vector");
  cover property (done && pwrite && interrupt_vector != 8'h00);
  cover property (done && pslverr);
  cover property (ext_int0_request && dma_done != 5'h00);
endmodule

bind vie_top vie_top_asserts #(.ADDR_W(ADDR_W)) vie_top_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dma_done(dma_done), .interrupt_vector(interrupt_vector),
  .ext_int0_request(ext_int0_request), .external_irq_out_n(external_irq_out_n));

/* tb/vie_mcu_model.sv */
// Processor model: APB master that services the vector while the request is low
`timescale 1ns/1ps
module vie_mcu_model (
  // Clock
  input wire pclk,
  // APB master
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Request from the encoder
  input wire external_irq_out_n
);
  // No cycle limit here: only the bench watchdog may end a stuck wait
  task automatic xfer(input logic w, input logic [11:0] a, output logic [31:0] d,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'h0000_005a;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Level sensitive: service only while the request is held low
  task automatic service(output logic [7:0] v);
    logic [31:0] d;
    logic e;
    v = 8'h00;
    if (external_irq_out_n === 1'b0)
    begin
      xfer(1'b0, 12'h000, d, e);
      v = d[7:0];
      xfer(1'b1, 12'h000, d, e);
    end
  endtask
endmodule

/* tb/vectored_interrupt_encoder_test.sv */
// Self-checking bench for the vectored interrupt encoder
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("BAD t=%0t got %h exp %h", $time, a, b); \
    end \
  end
module vectored_interrupt_encoder_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [41:0] src = '0;
  wire psel, penable, pwrite, pready, pslverr, irq_req, irq_n;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [7:0] vec, in_pend, out_pend;
  int errors = 0;
  int n_tests = 0;
  logic [7:0] v;
  logic [31:0] d;
  logic e;
  logic [7:0] exp_tab [42] = '{8'h46, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e,
    8'h44, 8'h22, 8'h24, 8'h26, 8'h28, 8'h2a, 8'h2c, 8'h2e, 8'h30, 8'h32, 8'h38, 8'h3a,
    8'h3c, 8'h3e, 8'h40, 8'h42, 8'h50, 8'h54, 8'h52, 8'h56, 8'h60, 8'h64, 8'h62, 8'h66,
    8'h70, 8'h72, 8'h74, 8'h76, 8'h78, 8'h80, 8'h82, 8'h84, 8'h86, 8'h88};

  vie_top vie_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_ep_event(src[7:0]), .in_ep_event(src[15:8]), .setup_overwrite(src[16]),
    .setup_received(src[17]), .usb_resume_event(src[18]), .usb_suspend_event(src[19]),
    .usb_bus_reset_event(src[20]), .usb_wakeup_event(src[21]),
    .i2c_transmit_empty(src[22]), .i2c_receive_full(src[23]),
    .uart_line_status(src[25:24]), .uart_modem_status(src[27:26]),
    .uart_receive_full(src[29:28]), .uart_transmit_empty(src[31:30]),
    .parallel_port_receive_full(src[32]), .parallel_port_transmit_empty(src[33]),
    .printer_fault(src[34]), .parallel_port_ack(src[35]), .paper_error(src[36]),
    .dma_done(src[41:37]), .interrupt_vector(vec), .ext_int0_request(irq_req),
    .external_irq_out_n(irq_n), .input_endpoint_pending(in_pend),
    .output_endpoint_pending(out_pend));

  vie_mcu_model mcu (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_irq_out_n(irq_n));

  initial
  begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic pulse(input logic [41:0] m);
    @(posedge pclk);
    src <= m;
    @(posedge pclk);
    src <= '0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(vec, 8'h00)
    `CHK(irq_n, 1'b1)
    mcu.xfer(1'b0, 12'h000, d, e);
    `CHK(d, 32'h0)
    $display("test reset done");
    for (int i = 0; i < 42; i++)
    begin
      pulse(42'h1 << i);
      `CHK({in_pend, out_pend}, (i < 16) ? 16'h1 << i : 16'h0)
      mcu.service(v);
      `CHK(v, exp_tab[i])
      @(posedge pclk);
      `CHK(vec, 8'h00)
      `CHK({in_pend, out_pend}, 16'h0)
    end
    $display("test source table done");
    // Lowest and highest source together: group order decides
    pulse(42'h200_0000_0002);
    mcu.service(v);
    `CHK(v, 8'h88)
    mcu.service(v);
    `CHK(v, 8'h12)
    $display("test group priority done");
    // Arrival order decides within a group, not the index
    pulse(42'h1 << 40);
    pulse(42'h1 << 39);
    pulse(42'h1 << 37);
    pulse(42'h1 << 38);
    mcu.xfer(1'b1, 12'h004, d, e);
    `CHK(e, 1'b1)
    @(posedge pclk);
    `CHK(vec, 8'h86)
    mcu.service(v);
    `CHK(v, 8'h86)
    mcu.service(v);
    `CHK(v, 8'h84)
    mcu.service(v);
    `CHK(v, 8'h80)
    mcu.service(v);
    `CHK(v, 8'h82)
    @(posedge pclk);
    `CHK(irq_n, 1'b1)
    `CHK(irq_req, 1'b0)
    $display("test arrival order done");
    end_of_test();
  end

  initial
  begin
    #50000;
    errors++;
    end_of_test();
  end
endmodule
